// file: include/dac_pkg.sv
/*
  Shared constants and types of the dual converter serial loader:
  serial word layout, latch reset values, select codes, frame states
  and the register map seen from the APB side.
  Assumes a 32-bit APB with word-aligned registers.
*/
package dac_pkg;

  // Serial word
  localparam int WORD_BITS = 16;
  localparam int CNT_W = 5;
  localparam int DATA_W = 8;
  localparam logic [CNT_W-1:0] CNT_FULL = 5'h10;
  localparam int SEL_HIGH_BIT = 15;
  localparam int SPEED_BIT = 14;
  localparam int PD_BIT = 13;
  localparam int SEL_LOW_BIT = 12;
  localparam int DATA_MSB = 11;
  localparam int DATA_LSB = 4;

  // Select codes {select_high, select_low}
  localparam logic [1:0] SEL_DAC_B = 2'h0;
  localparam logic [1:0] SEL_BUFFER = 2'h1;
  localparam logic [1:0] SEL_DAC_A = 2'h2;
  localparam logic [1:0] SEL_RESERVED = 2'h3;

  // Reset values
  localparam logic [DATA_W-1:0] LATCH_RST = 8'h00;
  localparam logic SPEED_RST = 1'b0;
  localparam logic PD_RST = 1'b0;
  localparam logic [WORD_BITS-1:0] WORD_RST = 16'h0000;

  // Register map
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] OFF_CONTROL = 12'h000;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 12'h004;
  localparam logic [ADDR_W-1:0] OFF_CHANNELS = 12'h008;
  localparam logic [ADDR_W-1:0] OFF_WORDS = 12'h00C;
  localparam int CTRL_ACCEPT_BIT = 0;
  localparam int CTRL_CLR_COUNT_BIT = 1;
  localparam int CTRL_CLR_PARTIAL_BIT = 2;
  localparam logic CTRL_ACCEPT_RST = 1'b1;
  localparam int STAT_SPEED_BIT = 0;
  localparam int STAT_PD_BIT = 1;
  localparam int STAT_BUSY_BIT = 2;
  localparam int STAT_PARTIAL_BIT = 3;
  localparam int CHAN_A_LSB = 0;
  localparam int CHAN_B_LSB = 8;
  localparam int CHAN_BUF_LSB = 16;
  localparam int WCOUNT_W = 16;
  localparam logic [WCOUNT_W-1:0] WCOUNT_RST = 16'h0000;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;

  typedef enum logic {FRAME_IDLE, FRAME_OPEN} frame_state_t;

endpackage

// file: include/link_if.sv
/*
  Signals passed from the serial-clock shifter to the pclk core.
  Toggles announce events; words are stable while their toggle is seen.
*/
`timescale 1ns/1ps
`default_nettype none
interface link_if;
  logic [dac_pkg::WORD_BITS-1:0] shift_word;
  logic [dac_pkg::WORD_BITS-1:0] done_word;
  logic start_tgl;
  logic done_tgl;
  modport link (output shift_word, output done_word, output start_tgl, output done_tgl);
  modport core (input shift_word, input done_word, input start_tgl, input done_tgl);
endinterface
`default_nettype wire

// file: rtl/serial_shifter.sv
/*
  Serial-clock side of the loader: samples data on falling edges,
  counts bits per select-low period and marks a full word on the
  rising edge after the last bit.
  Assumes sclk, cs_n and din come from the same host with setup times met.
*/
`timescale 1ns/1ps
`default_nettype none
module serial_shifter (
  input wire logic sclk,
  input wire logic presetn,
  input wire logic cs_n,
  input wire logic din,
  link_if.link lnk
);
  import dac_pkg::*;

  logic [WORD_BITS-1:0] shift;
  logic [WORD_BITS-1:0] next_shift;
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;
  logic start_tgl;
  logic next_start_tgl;
  logic done_flag;
  logic next_done_flag;
  logic done_tgl;
  logic next_done_tgl;
  logic [WORD_BITS-1:0] done_word;
  logic [WORD_BITS-1:0] next_done_word;

  // Falling edge sampling, MSB first
  always_comb begin
    next_shift = shift;
    next_count = count;
    next_start_tgl = start_tgl;
    if (!cs_n && count != CNT_FULL) begin // RULE_15
      next_shift = {shift[WORD_BITS-2:0], din}; // RULE_01
      next_count = count + 5'h01; // RULE_13
      if (count == '0) begin
        next_shift = {{(WORD_BITS-1){1'b0}}, din};
        next_start_tgl = ~start_tgl;
      end
    end
  end

  always_ff @(negedge sclk or negedge presetn) begin
    if (!presetn) begin
      shift <= WORD_RST;
      start_tgl <= 1'b0;
    end else begin
      shift <= next_shift;
      start_tgl <= next_start_tgl;
    end
  end

  // Select high clears the count
  always_ff @(negedge sclk or negedge presetn or posedge cs_n) begin
    if (!presetn) begin
      count <= '0;
    end else if (cs_n) begin
      count <= '0; // RULE_17 RULE_14
    end else begin
      count <= next_count;
    end
  end

  // Rising edge after the last bit hands the word over
  always_comb begin
    next_done_flag = done_flag;
    next_done_tgl = done_tgl;
    next_done_word = done_word;
    if (!cs_n && count == CNT_FULL && !done_flag) begin // RULE_11
      next_done_flag = 1'b1;
      next_done_tgl = ~done_tgl;
      next_done_word = shift;
    end
  end

  always_ff @(posedge sclk or negedge presetn or posedge cs_n) begin
    if (!presetn) begin
      done_flag <= 1'b0;
    end else if (cs_n) begin
      done_flag <= 1'b0;
    end else begin
      done_flag <= next_done_flag;
    end
  end

  always_ff @(posedge sclk or negedge presetn) begin
    if (!presetn) begin
      done_tgl <= 1'b0;
      done_word <= WORD_RST;
    end else begin
      done_tgl <= next_done_tgl;
      done_word <= next_done_word;
    end
  end

  assign lnk.shift_word = shift;
  assign lnk.done_word = done_word;
  assign lnk.start_tgl = start_tgl;
  assign lnk.done_tgl = done_tgl;

endmodule
`default_nettype wire

// file: rtl/dual_dac_serial_loader.sv
/*
  Dual 8-bit converter loader: serial word reception, latch routing,
  speed and power-down control, and an APB register view.
  Assumes sclk is the host's serial clock, idle outside frames, and
  that APB runs on pclk with presetn as its reset.
*/
// What this block does
// RULE_01: After select falls, one data bit is sampled per falling serial clock edge, MSB first.
// RULE_02: The shifted word moves to its target latch after sixteen bits or when select rises early.
// RULE_03: Bit 15 is select-high, 14 speed, 13 power-down, 12 select-low, 11..4 data, 3..0 zero.
// RULE_04: A speed bit of 1 selects fast mode and 0 slow low-power mode.
// RULE_05: A power-down bit of 1 enters power-down with all other bits ignored; 0 runs normally.
// RULE_06: At power-up speed and power-down both clear, giving slow mode and normal operation.
// RULE_07: Reset clears both channel latches and the holding buffer to zero.
// RULE_08: Select code 00 writes the data to the holding buffer and to channel B.
// RULE_09: Select code 01 writes the data only to the holding buffer, outputs unchanged.
// RULE_10: Select code 10 loads channel A and copies the holding buffer into channel B.
// RULE_11: Latches update on the rising serial clock edge after the sixteenth bit; here they update on a later pclk edge, once the done toggle is synchronised.
// RULE_12: A channel A word with buffer transfer changes both outputs together.
// RULE_13: An 8-bit host sends two back-to-back writes inside one select-low period.
// RULE_14: The host drives select low before it starts clocking data.
// RULE_15: Select is active low and clock and data count only while it is low.
// RULE_16: The reserved select code 11 leaves all channel latches and the buffer unchanged.
// RULE_17: Serial activity with select high is ignored and each frame restarts the count.
`timescale 1ns/1ps
`default_nettype none
module dual_dac_serial_loader (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [dac_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  output logic [dac_pkg::DATA_W-1:0] channel_a_output,
  output logic [dac_pkg::DATA_W-1:0] channel_b_output,
  output logic speed_select,
  output logic powerdown_flag
);
  import dac_pkg::*;

  link_if lnk ();

  serial_shifter u_shifter (
    .sclk(sclk),
    .presetn(presetn),
    .cs_n(cs_n),
    .din(din),
    .lnk(lnk)
  );

  // Crossing into pclk
  logic cs_s1;
  logic cs_s2;
  logic cs_prev;
  logic start_s1;
  logic start_s2;
  logic start_prev;
  logic done_s1;
  logic done_s2;
  logic done_prev;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      cs_prev <= 1'b1;
      start_s1 <= 1'b0;
      start_s2 <= 1'b0;
      start_prev <= 1'b0;
      done_s1 <= 1'b0;
      done_s2 <= 1'b0;
      done_prev <= 1'b0;
    end else begin
      cs_s1 <= cs_n;
      cs_s2 <= cs_s1;
      cs_prev <= cs_s2;
      start_s1 <= lnk.start_tgl;
      start_s2 <= start_s1;
      start_prev <= start_s2;
      done_s1 <= lnk.done_tgl;
      done_s2 <= done_s1;
      done_prev <= done_s2;
    end
  end

  logic start_evt;
  logic done_evt;
  logic cs_rise;

  assign start_evt = start_s2 ^ start_prev;
  assign done_evt = done_s2 ^ done_prev;
  assign cs_rise = cs_s2 & ~cs_prev;

  // Frame tracking
  frame_state_t state;
  frame_state_t next_state;
  logic commit;
  logic commit_partial;
  logic [WORD_BITS-1:0] commit_word;

  always_comb begin
    next_state = state;
    commit = 1'b0;
    commit_partial = 1'b0;
    commit_word = lnk.done_word;
    case (state)
      FRAME_IDLE: begin
        if (start_evt && done_evt) begin
          commit = 1'b1; // RULE_11
        end else if (start_evt && cs_rise) begin
          commit = 1'b1;
          commit_partial = 1'b1;
          commit_word = lnk.shift_word;
        end else if (start_evt) begin
          next_state = FRAME_OPEN;
        end
      end
      FRAME_OPEN: begin
        if (done_evt) begin
          commit = 1'b1; // RULE_02
          next_state = FRAME_IDLE;
        end else if (cs_rise) begin
          commit = 1'b1; // RULE_02
          commit_partial = 1'b1;
          commit_word = lnk.shift_word;
          next_state = FRAME_IDLE;
        end
      end
      default: begin
        next_state = FRAME_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= FRAME_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Register file state
  logic accept;
  logic next_accept;
  logic [WCOUNT_W-1:0] word_count;
  logic [WCOUNT_W-1:0] next_word_count;
  logic partial_seen;
  logic next_partial_seen;
  logic [31:0] next_prdata;

  // Word decode
  logic sel_high;
  logic sel_low;
  logic word_speed;
  logic word_pd;
  logic [DATA_W-1:0] word_data;
  logic apply;

  assign sel_high = commit_word[SEL_HIGH_BIT]; // RULE_03
  assign sel_low = commit_word[SEL_LOW_BIT];
  assign word_speed = commit_word[SPEED_BIT];
  assign word_pd = commit_word[PD_BIT];
  assign word_data = commit_word[DATA_MSB:DATA_LSB];
  assign apply = commit & accept;

  // Latches
  logic [DATA_W-1:0] buf_latch;
  logic [DATA_W-1:0] next_buf_latch;
  logic [DATA_W-1:0] a_latch;
  logic [DATA_W-1:0] next_a_latch;
  logic [DATA_W-1:0] b_latch;
  logic [DATA_W-1:0] next_b_latch;
  logic speed;
  logic next_speed;
  logic pd;
  logic next_pd;

  always_comb begin
    next_buf_latch = buf_latch;
    next_a_latch = a_latch;
    next_b_latch = b_latch;
    next_speed = speed;
    next_pd = pd;
    if (apply) begin
      if (word_pd) begin
        next_pd = 1'b1; // RULE_05
      end else begin
        next_pd = 1'b0; // RULE_05
        next_speed = word_speed; // RULE_04
        case ({sel_high, sel_low})
          SEL_DAC_B: begin
            next_buf_latch = word_data; // RULE_08
            next_b_latch = word_data; // RULE_08
          end
          SEL_BUFFER: begin
            next_buf_latch = word_data; // RULE_09
          end
          SEL_DAC_A: begin
            next_a_latch = word_data; // RULE_10 RULE_12
            next_b_latch = buf_latch; // RULE_10 RULE_12
          end
          SEL_RESERVED: begin
            next_buf_latch = buf_latch; // RULE_16
          end
          default: begin
            next_buf_latch = buf_latch;
          end
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buf_latch <= LATCH_RST; // RULE_07
      a_latch <= LATCH_RST; // RULE_07
      b_latch <= LATCH_RST; // RULE_07
      speed <= SPEED_RST; // RULE_06
      pd <= PD_RST; // RULE_06
    end else begin
      buf_latch <= next_buf_latch;
      a_latch <= next_a_latch;
      b_latch <= next_b_latch;
      speed <= next_speed;
      pd <= next_pd;
    end
  end

  assign channel_a_output = a_latch;
  assign channel_b_output = b_latch;
  assign speed_select = speed;
  assign powerdown_flag = pd;

  // APB slave
  logic setup;
  logic access;
  logic mapped;
  logic wr_control;

  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign mapped = (paddr == OFF_CONTROL) | (paddr == OFF_STATUS)
                | (paddr == OFF_CHANNELS) | (paddr == OFF_WORDS);
  assign wr_control = access & pwrite & (paddr == OFF_CONTROL);
  assign pready = 1'b1;
  assign pslverr = access & ~mapped;

  always_comb begin
    next_accept = accept;
    next_word_count = word_count;
    next_partial_seen = partial_seen;
    if (wr_control) begin
      next_accept = pwdata[CTRL_ACCEPT_BIT];
      if (pwdata[CTRL_CLR_COUNT_BIT]) begin
        next_word_count = '0;
      end
      if (pwdata[CTRL_CLR_PARTIAL_BIT]) begin
        next_partial_seen = 1'b0;
      end
    end
    // Events win over a clear in the same cycle
    if (commit) begin
      if (wr_control && pwdata[CTRL_CLR_COUNT_BIT]) begin
        next_word_count = 16'h0001;
      end else begin
        next_word_count = word_count + 16'h0001;
      end
      if (commit_partial) begin
        next_partial_seen = 1'b1;
      end
    end
  end

  always_comb begin
    next_prdata = prdata;
    if (setup) begin
      next_prdata = RDATA_RST;
      case (paddr)
        OFF_CONTROL: begin
          next_prdata[CTRL_ACCEPT_BIT] = accept;
        end
        OFF_STATUS: begin
          next_prdata[STAT_SPEED_BIT] = speed;
          next_prdata[STAT_PD_BIT] = pd;
          next_prdata[STAT_BUSY_BIT] = (state == FRAME_OPEN);
          next_prdata[STAT_PARTIAL_BIT] = partial_seen;
        end
        OFF_CHANNELS: begin
          next_prdata[CHAN_A_LSB +: DATA_W] = a_latch;
          next_prdata[CHAN_B_LSB +: DATA_W] = b_latch;
          next_prdata[CHAN_BUF_LSB +: DATA_W] = buf_latch;
        end
        OFF_WORDS: begin
          next_prdata[WCOUNT_W-1:0] = word_count;
        end
        default: begin
          next_prdata = RDATA_RST;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      accept <= CTRL_ACCEPT_RST;
      word_count <= WCOUNT_RST;
      partial_seen <= 1'b0;
      prdata <= RDATA_RST;
    end else begin
      accept <= next_accept;
      word_count <= next_word_count;
      partial_seen <= next_partial_seen;
      prdata <= next_prdata;
    end
  end

endmodule
`default_nettype wire

// file: dv/dac_loader_sva.sv
/* Port checker for the dual converter loader.
   Assumes it is bound to dual_dac_serial_loader and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module dac_loader_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [dac_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic cs_n,
  input wire logic [dac_pkg::DATA_W-1:0] channel_a_output,
  input wire logic [dac_pkg::DATA_W-1:0] channel_b_output,
  input wire logic speed_select,
  input wire logic powerdown_flag
);
  import dac_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_rd_setup(logic [ADDR_W-1:0] a);
    psel && !penable && !pwrite && paddr == a;
  endsequence
  sequence s_access;
    psel && penable;
  endsequence
  property p_reset_clear;
    $rose(presetn) |-> channel_a_output == LATCH_RST && channel_b_output == LATCH_RST
      && speed_select == SPEED_RST && powerdown_flag == PD_RST;
  endproperty
  property p_idle_stable;
    cs_n [*8] |-> $stable(channel_a_output) && $stable(channel_b_output)
      && $stable(speed_select) && $stable(powerdown_flag);
  endproperty
  property p_ready;
    psel |-> pready;
  endproperty
  property p_err_unmapped;
    s_access and paddr > OFF_WORDS |-> pslverr;
  endproperty
  property p_err_mapped;
    s_access and paddr[1:0] == 2'h0 && paddr <= OFF_WORDS |-> !pslverr;
  endproperty
  property p_status;
    s_rd_setup(OFF_STATUS) ##1 s_access |->
      prdata[1:0] == {$past(powerdown_flag), $past(speed_select)};
  endproperty
  property p_channels;
    s_rd_setup(OFF_CHANNELS) ##1 s_access |->
      prdata[15:0] == {$past(channel_b_output), $past(channel_a_output)};
  endproperty
  property p_pd_only;
    $rose(powerdown_flag) |-> $stable(speed_select) && $stable(channel_a_output)
      && $stable(channel_b_output);
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("outputs not clear");
  a_idle_stable: assert property (p_idle_stable) else $error("change while idle");
  a_ready: assert property (p_ready) else $error("pready low");
  a_err_unmapped: assert property (p_err_unmapped) else $error("no pslverr");
  a_err_mapped: assert property (p_err_mapped) else $error("bad pslverr");
  a_status: assert property (p_status) else $error("status view wrong");
  a_channels: assert property (p_channels) else $error("channel view wrong");
  a_pd_only: assert property (p_pd_only) else $error("power-down moved more");
endmodule
bind dual_dac_serial_loader dac_loader_sva chk_u (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .cs_n(cs_n), .channel_a_output(channel_a_output),
  .channel_b_output(channel_b_output), .speed_select(speed_select),
  .powerdown_flag(powerdown_flag));
`default_nettype wire

// file: dv/serial_host.sv
/* Serial host model: frames words on select, clock and data.
   Assumes a 12 ns link clock that stands high between frames. */
`timescale 1ns/1ps
`default_nettype none
module serial_host (
  output logic sclk,
  output logic cs_n,
  output logic din
);
  initial begin
    sclk = 1'h1;
    cs_n = 1'h1;
    din = 1'h0;
  end
  // Sends n bits MSB first; extra bits past 16 alternate
  task automatic frame(input logic [15:0] w, input int n, input int gap);
    int i;
    cs_n = 1'h0;
    #11;
    for (i = 0; i < n; i++) begin
      din = (i < 16) ? w[15-i] : i[0];
      #6 sclk = 1'h0;
      #6 sclk = 1'h1;
      if (i == 7 && gap > 0) #(gap);
    end
    #11 cs_n = 1'h1;
    din = ~din;
    #25;
  endtask
  // Clock and data toggling with select high
  task automatic stray(input int n);
    int i;
    for (i = 0; i < n; i++) begin
      din = ~din;
      #6 sclk = 1'h0;
      #6 sclk = 1'h1;
    end
  endtask
endmodule
`default_nettype wire

// file: dv/testbench.sv
/* Self-checking bench for the dual converter loader.
   Assumes dac_pkg, link_if and the design files are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import dac_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic sclk, cs_n, din, speed_select, powerdown_flag;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [DATA_W-1:0] channel_a_output, channel_b_output, want_a, want_b, held_buf;
  logic want_speed, want_pd, accept;
  int error_cnt = 0;
  int comparisons = 0;
  int sent = 0;
  dual_dac_serial_loader dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sclk(sclk), .cs_n(cs_n), .din(din),
    .channel_a_output(channel_a_output), .channel_b_output(channel_b_output),
    .speed_select(speed_select), .powerdown_flag(powerdown_flag));
  serial_host host_u (.sclk(sclk), .cs_n(cs_n), .din(din));
  initial begin
    pclk = 1'h0;
    forever #2.5 pclk = ~pclk;
  end
  task automatic wrap_up();
    if (error_cnt == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic do_reset();
    @(posedge pclk);
    presetn <= 1'h0;
    repeat (12) @(posedge pclk);
    presetn <= 1'h1;
    {want_a, want_b, held_buf} = {3{LATCH_RST}};
    {want_speed, want_pd, accept} = {SPEED_RST, PD_RST, CTRL_ACCEPT_RST};
    sent = 0;
    repeat (3) @(posedge pclk);
  endtask
  task automatic check_outputs();
    logic [31:0] rd;
    logic err;
    chk("channel_a", 32'(want_a), 32'(channel_a_output));
    chk("channel_b", 32'(want_b), 32'(channel_b_output));
    chk("mode", 32'({want_pd, want_speed}), 32'({powerdown_flag, speed_select}));
    apb(1'h0, OFF_CHANNELS, 32'h0, rd, err);
    chk("channels_reg", {8'h00, held_buf, want_b, want_a}, rd);
    apb(1'h0, OFF_STATUS, 32'h0, rd, err);
    chk("status_reg", 32'({want_pd, want_speed}), 32'(rd[1:0]));
  endtask
  task automatic model(input logic [15:0] e);
    logic [7:0] d;
    d = e[DATA_MSB:DATA_LSB];
    if (accept && e[PD_BIT])
      want_pd = 1'h1;
    else if (accept) begin
      want_pd = 1'h0;
      want_speed = e[SPEED_BIT];
      case ({e[SEL_HIGH_BIT], e[SEL_LOW_BIT]})
        SEL_DAC_B: begin
          held_buf = d;
          want_b = d;
        end
        SEL_BUFFER: held_buf = d;
        SEL_DAC_A: begin
          want_a = d;
          want_b = held_buf;
        end
        default: ;
      endcase
    end
  endtask
  // Sends a frame, watches channel A and B move together, then checks all outputs
  task automatic xfer(input logic [15:0] w, input int n, input int gap);
    logic [7:0] old_a;
    int k;
    old_a = channel_a_output;
    model(n >= 16 ? w : w >> (16 - n));
    sent++;
    fork
      host_u.frame(w, n, gap);
      for (k = 0; k < 120; k++) begin
        @(negedge pclk);
        if (channel_a_output !== old_a) begin
          chk("b_with_a", 32'(want_b), 32'(channel_b_output));
          break;
        end
      end
    join
    repeat (12) @(posedge pclk);
    check_outputs();
  endtask
  task automatic t_reset();
    logic [31:0] rd;
    logic err;
    check_outputs();
    apb(1'h0, OFF_CONTROL, 32'h0, rd, err);
    chk("accept_rst", 32'(CTRL_ACCEPT_RST), 32'(rd[CTRL_ACCEPT_BIT]));
  endtask
  task automatic t_routes();
    xfer(16'h15A0, 16, 0);
    xfer(16'h43C0, 16, 0);
    xfer(16'h1960, 16, 0);
    xfer(16'h8C30, 16, 0);
  endtask
  task automatic t_modes();
    xfer(16'hDFF0, 16, 0);
    xfer(16'h2110, 16, 0);
    xfer(16'h0220, 16, 0);
  endtask
  task automatic t_framing();
    logic [31:0] rd;
    logic err;
    host_u.stray(6);
    check_outputs();
    xfer(16'h1770, 16, 40);
    xfer(16'hA5F0, 12, 0);
    apb(1'h0, OFF_STATUS, 32'h0, rd, err);
    chk("early_flag", 32'h1, 32'(rd[STAT_PARTIAL_BIT]));
    xfer(16'h4660, 20, 0);
  endtask
  task automatic t_apb();
    logic [31:0] rd;
    logic err;
    apb(1'h0, 12'h010, 32'h0, rd, err);
    chk("unmapped_err", 32'h1, 32'(err));
    chk("unmapped_data", 32'h0, rd);
    apb(1'h1, OFF_CONTROL, 32'h0, rd, err);
    accept = 1'h0;
    xfer(16'h4AB0, 16, 0);
    apb(1'h0, OFF_WORDS, 32'h0, rd, err);
    chk("word_count", 32'(sent), rd);
    apb(1'h1, OFF_CONTROL, 32'h6, rd, err);
    apb(1'h0, OFF_CONTROL, 32'h0, rd, err);
    chk("accept_off", 32'h0, rd);
    apb(1'h0, OFF_WORDS, 32'h0, rd, err);
    chk("count_clear", 32'h0, rd);
    apb(1'h0, OFF_STATUS, 32'h0, rd, err);
    chk("partial_clear", 32'h0, 32'(rd[STAT_PARTIAL_BIT]));
  endtask
  initial begin
    {presetn, psel, penable, pwrite} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    do_reset();
    t_reset();
    t_routes();
    t_modes();
    t_framing();
    t_apb();
    do_reset();
    t_reset();
    wrap_up();
  end
  initial begin
    #100000;
    error_cnt++;
    wrap_up();
  end
endmodule
`default_nettype wire
